//--- inc/mac_dp_pkg.sv
// package for the fixed-point multiply/accumulate datapath
// assumes a single processor clock and a sequencer that drives the control struct
package mac_dp_pkg;

  // ----------------------------------------------------------------
  // widths and layout
  // ----------------------------------------------------------------
  localparam int OPW       = 16;
  localparam int ACCW      = 24;
  localparam int PRODW     = 32;
  localparam int STACK_DEP = 6;
  localparam int SPW       = 3;
  localparam int SHIFT_AMT = 3;

  // status bit positions
  localparam int SR_NEG   = 15;
  localparam int SR_OVF   = 14;
  localparam int SR_ZERO  = 13;
  localparam int SR_CARRY = 12;
  localparam int SR_UI1   = 11;
  localparam int SR_UI0   = 10;
  localparam int SR_SHIFT = 9;
  localparam int SR_CLAMP = 8;
  localparam int SR_UO1   = 6;
  localparam int SR_UO0   = 5;

  // writable status bits (9..0); flags and user inputs are read only
  localparam logic [15:0] SR_WMASK   = 16'h03FF;
  localparam logic [15:0] SR_RESET   = 16'h0000;
  localparam logic [23:0] ACC_MAXPOS = 24'h7FFFFF;
  localparam logic [23:0] ACC_MAXNEG = 24'h800000;
  localparam logic [15:0] MOST_NEG   = 16'h8000;
  localparam logic [15:0] RET_STEP   = 16'h0002;

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ALU_NOP, ALU_LOAD, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR,
    ALU_SHL, ALU_SHR, ALU_NEG, ALU_ABS, ALU_PASS
  } alu_op_t;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_X, SRC_Y, SRC_P, SRC_ACC, SRC_SR, SRC_STACK
  } rd_src_t;

  typedef struct packed {
    logic    loadX;       // operand bus into first factor
    logic    loadY;       // operand bus into second factor
    logic    square;      // bank switch: one operand into both factors
    logic    mulEn;       // update product register
    logic    prodShiftReq; // multiply/shift option of the instruction
    alu_op_t aluOp;
    logic    aluSelProd;  // second ALU input: product or operand bus
    logic    writeSr;
    logic    push;
    logic    pop;
    logic    call;        // push return address
    logic    subroutineReturnOp;
    logic    longInstr;   // two-cycle instruction
    rd_src_t readSrc;
  } dp_ctrl_t;

  typedef struct packed {
    logic [OPW-1:0] readData;
    logic [OPW-1:0] instructionPointer;
    logic           ipLoad;
    logic           busy;
    logic           stackFull;
    logic           stackEmpty;
  } dp_status_t;

endpackage

//--- src/mac_alu_datapath.sv
// multiply/accumulate datapath: factors, product, accumulator, status, stack
// assumes the sequencer sets ctrl only when ready is high and steps ipIn itself
//
// Functional notes
// - most instructions, multiply and MAC included, take one cycle
// - long-immediate, call and return instructions take two cycles
// - signed 16x16 multiply or MAC from the two factor registers
// - full 32-bit product, keep 24 MSBs by truncation
// - operands and result are fractional two's complement
// - most negative times most negative returns most negative, no saturation
// - shifter passes product unshifted or arithmetic right by three
// - bank switch loads both factors for squaring; also serves X reads
// - ALU inputs: accumulator and product or left-justified operand bus
// - ALU does arithmetic, logic and shifts into the accumulator
// - six-entry stack on the operand bus for returns or data
// - call pushes address plus two; return pops into the instruction pointer
// - user inputs drive status bits 10 and 11
// - user outputs follow status bits 5 and 6
// - each user output is the inverse of its status bit
// - status bit 9 with shift option applies the three-bit shift
// - status bit 8 clamps arithmetic results on overflow
// - 16-bit loads fill accumulator MSBs; reads give upper 16 bits
// - ALU updates negative, overflow, zero, carry in bits 15..12
`timescale 1ns/1ps

module mac_alu_datapath
  import mac_dp_pkg::*;
(
  // clock and reset
  input  wire logic           clk_sys,
  input  wire logic           rstn,
  input  wire logic           clkEn,
  // control from sequencer
  input  wire dp_ctrl_t       ctrl,
  input  wire logic           ctrlValid,
  input  wire logic [OPW-1:0] sharedOperandBus,
  input  wire logic [OPW-1:0] ipIn,
  // user pins
  input  wire logic           userInputZero,
  input  wire logic           userInputOne,
  output logic                userOutputZero,
  output logic                userOutputOne,
  // results
  output dp_status_t          status,
  output logic [ACCW-1:0]     accOut,
  output logic [15:0]         statusReg,
  output logic                ready
);

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstSync_r;
  logic       rstLocal;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rstSync_r <= 2'h0;
    else
      rstSync_r <= {rstSync_r[0], 1'b1};
  end
  assign rstLocal = rstSync_r[1];

  // pins are asynchronous; a change counts once stages two and three agree
  logic [2:0] ui0Sync_r;
  logic [2:0] ui1Sync_r;
  logic       ui0Stable_r;
  logic       ui1Stable_r;
  always_ff @(posedge clk_sys or negedge rstLocal)
  begin
    if (!rstLocal)
    begin
      ui0Sync_r   <= 3'h0;
      ui1Sync_r   <= 3'h0;
      ui0Stable_r <= 1'b0;
      ui1Stable_r <= 1'b0;
    end
    else if (clkEn)
    begin
      ui0Sync_r <= {ui0Sync_r[1:0], userInputZero};
      ui1Sync_r <= {ui1Sync_r[1:0], userInputOne};
      if (ui0Sync_r[1] == ui0Sync_r[2])
        ui0Stable_r <= ui0Sync_r[2];
      if (ui1Sync_r[1] == ui1Sync_r[2])
        ui1Stable_r <= ui1Sync_r[2];
    end
  end

  // ----------------------------------------------------------------
  // instruction timing
  // ----------------------------------------------------------------
  logic secondCycle_r;
  logic fire;
  assign fire = clkEn && ctrlValid && !secondCycle_r;

  always_ff @(posedge clk_sys or negedge rstLocal)
  begin
    if (!rstLocal)
      secondCycle_r <= 1'b0;
    else if (clkEn)
      secondCycle_r <= fire && (ctrl.longInstr || ctrl.call || ctrl.subroutineReturnOp);
  end

  always_ff @(posedge clk_sys or negedge rstLocal)
  begin
    if (!rstLocal)
      ready <= 1'b0;
    else if (clkEn)
      ready <= !(fire && (ctrl.longInstr || ctrl.call || ctrl.subroutineReturnOp));
  end

  // ----------------------------------------------------------------
  // factor registers and multiplier
  // ----------------------------------------------------------------
  logic [OPW-1:0]  factX_r;
  logic [OPW-1:0]  factY_r;
  logic [ACCW-1:0] prod_r;
  logic [15:0]     sr_r;

  always_ff @(posedge clk_sys or negedge rstLocal)
  begin
    if (!rstLocal)
    begin
      factX_r <= 16'h0000;
      factY_r <= 16'h0000;
    end
    else if (fire)
    begin
      if (ctrl.loadX || ctrl.square)
        factX_r <= sharedOperandBus;
      if (ctrl.loadY || ctrl.square)
        factY_r <= sharedOperandBus;
    end
  end

  logic signed [PRODW-1:0] fullProd;
  logic signed [ACCW-1:0]  prodTop;
  logic        [ACCW-1:0]  prodShifted;
  always_comb
  begin
    // fractional: product << 1 aligns the binary point, 8000*8000 wraps to 8000
    fullProd = PRODW'($signed(factX_r) * $signed(factY_r)) <<< 1;
    prodTop  = fullProd[PRODW-1 -: ACCW];
    if (ctrl.prodShiftReq && sr_r[SR_SHIFT])
      prodShifted = ACCW'(prodTop >>> SHIFT_AMT);
    else
      prodShifted = prodTop;
  end

  always_ff @(posedge clk_sys or negedge rstLocal)
  begin
    if (!rstLocal)
      prod_r <= 24'h000000;
    else if (fire && ctrl.mulEn)
      prod_r <= prodShifted;
  end

  // ----------------------------------------------------------------
  // ALU and accumulator
  // ----------------------------------------------------------------
  logic [ACCW-1:0] acc_r;
  logic [ACCW-1:0] aluB;
  logic [ACCW:0]   aluWide;
  logic [ACCW-1:0] aluRes;
  logic            aluOvf;
  logic            aluCarry;
  logic            isArith;

  always_comb
  begin
    aluB     = ctrl.aluSelProd ? prod_r : {sharedOperandBus, 8'h00};
    aluWide  = {1'b0, acc_r};
    aluOvf   = 1'b0;
    isArith  = 1'b0;
    case (ctrl.aluOp)
      ALU_LOAD: aluWide = {1'b0, aluB};
      ALU_ADD:
      begin
        aluWide = {1'b0, acc_r} + {1'b0, aluB};
        aluOvf  = (acc_r[ACCW-1] == aluB[ACCW-1]) && (aluWide[ACCW-1] != acc_r[ACCW-1]);
        isArith = 1'b1;
      end
      ALU_SUB:
      begin
        aluWide = {1'b0, acc_r} - {1'b0, aluB};
        aluOvf  = (acc_r[ACCW-1] != aluB[ACCW-1]) && (aluWide[ACCW-1] != acc_r[ACCW-1]);
        isArith = 1'b1;
      end
      ALU_AND:  aluWide = {1'b0, acc_r & aluB};
      ALU_OR:   aluWide = {1'b0, acc_r | aluB};
      ALU_XOR:  aluWide = {1'b0, acc_r ^ aluB};
      ALU_SHL:  aluWide = {acc_r, 1'b0};
      ALU_SHR:  aluWide = {acc_r[0], acc_r[ACCW-1], acc_r[ACCW-1:1]};
      ALU_NEG:
      begin
        aluWide = {1'b0, ~acc_r} + 25'h0000001;
        aluOvf  = (acc_r == ACC_MAXNEG);
        isArith = 1'b1;
      end
      ALU_ABS:
      begin
        aluWide = acc_r[ACCW-1] ? ({1'b0, ~acc_r} + 25'h0000001) : {1'b0, acc_r};
        aluOvf  = (acc_r == ACC_MAXNEG);
        isArith = 1'b1;
      end
      ALU_PASS: aluWide = {1'b0, aluB};
      default:  aluWide = {1'b0, acc_r};
    endcase
    aluCarry = aluWide[ACCW];
    aluRes   = aluWide[ACCW-1:0];
    // clamp toward the sign the true result would have had
    if (isArith && aluOvf && sr_r[SR_CLAMP])
      aluRes = aluRes[ACCW-1] ? ACC_MAXPOS : ACC_MAXNEG;
  end

  always_ff @(posedge clk_sys or negedge rstLocal)
  begin
    if (!rstLocal)
      acc_r <= 24'h000000;
    else if (fire && ctrl.aluOp != ALU_NOP)
      acc_r <= aluRes;
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstLocal)
  begin
    if (!rstLocal)
      sr_r <= SR_RESET;
    else if (clkEn)
    begin
      sr_r[SR_UI0] <= ui0Stable_r;
      sr_r[SR_UI1] <= ui1Stable_r;
      if (fire && ctrl.writeSr)
        sr_r[9:0] <= sharedOperandBus[9:0] & SR_WMASK[9:0];
      if (fire && ctrl.aluOp != ALU_NOP)
      begin
        sr_r[SR_NEG]   <= aluRes[ACCW-1];
        sr_r[SR_OVF]   <= aluOvf;
        sr_r[SR_ZERO]  <= (aluRes == 24'h000000);
        sr_r[SR_CARRY] <= aluCarry;
      end
    end
  end

  // ----------------------------------------------------------------
  // hardware stack
  // ----------------------------------------------------------------
  logic [OPW-1:0] stack_r [STACK_DEP];
  logic [SPW-1:0] sp_r;
  logic           doPush;
  logic           doPop;
  logic [OPW-1:0] pushVal;
  assign doPush  = fire && (ctrl.push || ctrl.call);
  assign doPop   = fire && (ctrl.pop || ctrl.subroutineReturnOp);
  assign pushVal = ctrl.call ? OPW'(ipIn + RET_STEP) : sharedOperandBus;

  // overflow drops the oldest entry; the pointer saturates rather than wrapping
  always_ff @(posedge clk_sys or negedge rstLocal)
  begin
    if (!rstLocal)
      sp_r <= 3'h0;
    else if (doPush && !doPop && sp_r != SPW'(STACK_DEP))
      sp_r <= sp_r + 3'h1;
    else if (doPop && !doPush && sp_r != 3'h0)
      sp_r <= sp_r - 3'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (doPush && !doPop)
    begin
      stack_r[0] <= pushVal;
      for (int i = 1; i < STACK_DEP; i++)
        stack_r[i] <= stack_r[i-1];
    end
    else if (doPop && !doPush)
    begin
      for (int i = 0; i < STACK_DEP - 1; i++)
        stack_r[i] <= stack_r[i+1];
    end
    else if (doPop && doPush)
      stack_r[0] <= pushVal;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstLocal)
  begin
    if (!rstLocal)
    begin
      status         <= '0;
      accOut         <= 24'h000000;
      statusReg      <= SR_RESET;
      userOutputZero <= 1'b1;
      userOutputOne  <= 1'b1;
    end
    else if (clkEn)
    begin
      accOut         <= acc_r;
      statusReg      <= sr_r;
      userOutputZero <= ~sr_r[SR_UO0];
      userOutputOne  <= ~sr_r[SR_UO1];
      status.stackFull  <= (sp_r == SPW'(STACK_DEP));
      status.stackEmpty <= (sp_r == 3'h0);
      status.busy       <= fire && (ctrl.longInstr || ctrl.call || ctrl.subroutineReturnOp);
      status.ipLoad     <= fire && ctrl.subroutineReturnOp;
      if (fire && ctrl.subroutineReturnOp)
        status.instructionPointer <= stack_r[0];
      case (ctrl.readSrc)
        SRC_X:     status.readData <= factX_r;
        SRC_Y:     status.readData <= factY_r;
        SRC_P:     status.readData <= prod_r[ACCW-1 -: OPW];
        SRC_ACC:   status.readData <= acc_r[ACCW-1 -: OPW];
        SRC_SR:    status.readData <= sr_r;
        SRC_STACK: status.readData <= stack_r[0];
        default:   status.readData <= 16'h0000;
      endcase
    end
  end

endmodule

//--- testbench/mac_alu_datapath_checker.sv
// port-level assertions for the multiply/accumulate datapath
// assumes a single clock domain and the bind below
`timescale 1ns/1ps

module mac_alu_datapath_checker
  import mac_dp_pkg::*;
(
  // clock and reset
  input wire logic            clk_sys,
  input wire logic            rstn,
  input wire logic            clkEn,
  // control
  input wire dp_ctrl_t        ctrl,
  input wire logic            ctrlValid,
  // pins and results
  input wire logic            userInputOne,
  input wire logic            userOutputZero,
  input wire logic            userOutputOne,
  input wire dp_status_t      status,
  input wire logic [ACCW-1:0] accOut,
  input wire logic [15:0]     statusReg,
  input wire logic            ready
);
  logic taken;
  logic twoCyc;
  assign taken  = ctrlValid && clkEn && ready;
  assign twoCyc = ctrl.longInstr || ctrl.call || ctrl.subroutineReturnOp;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_uo_zero_inv: assert property (userOutputZero == !statusReg[SR_UO0])
    else $error("user output zero not inverse of its bit");
  a_uo_one_inv: assert property (userOutputOne == !statusReg[SR_UO1])
    else $error("user output one not inverse of its bit");
  a_ui_sync_in: assert property ($rose(userInputOne) ##0 (userInputOne && clkEn)[*8] |-> statusReg[SR_UI1])
    else $error("user input one not seen in status");
  a_call_two_cyc: assert property (taken && ctrl.call |=> status.busy && !ready ##1 ready)
    else $error("call did not take two cycles");
  a_ret_ip_load: assert property (taken && ctrl.subroutineReturnOp |=> status.ipLoad && !ready)
    else $error("return did not load pointer");
  a_single_cyc: assert property (taken && !twoCyc |=> ready && !status.busy)
    else $error("short instruction stalled");
  a_acc_read: assert property (taken && ctrl.readSrc == SRC_ACC |=> status.readData == accOut[23:8])
    else $error("accumulator read not upper bits");
  a_sr_read: assert property (taken && ctrl.readSrc == SRC_SR |=> status.readData == statusReg)
    else $error("status read mismatch");
  a_neg_flag: assert property (statusReg[SR_NEG] == accOut[ACCW-1])
    else $error("negative flag differs from accumulator sign");
endmodule

bind mac_alu_datapath mac_alu_datapath_checker chk_u (
  .clk_sys, .rstn, .clkEn, .ctrl, .ctrlValid, .userInputOne,
  .userOutputZero, .userOutputOne, .status, .accOut, .statusReg, .ready);

//--- testbench/mac_alu_datapath_tb.sv
// self-checking bench for the multiply/accumulate datapath
// assumes seq_model drives instructions; results sampled at falling edges
`timescale 1ns/1ps

module mac_alu_datapath_tb;
  import mac_dp_pkg::*;
  logic       clk_sys;
  logic       rstn;
  logic       clkEn;
  logic       userInputZero;
  logic       userInputOne;
  wire        userOutputZero;
  wire        userOutputOne;
  wire        ready;
  dp_ctrl_t   ctrl;
  wire        ctrlValid;
  wire [15:0] sharedOperandBus;
  wire [15:0] ipIn;
  dp_status_t status;
  wire [23:0] accOut;
  wire [15:0] statusReg;
  int         errorCnt = 0;
  int         numChecks = 0;
  dp_ctrl_t   c;

  seq_model seq_u (.clk_sys, .ready, .ctrl, .ctrlValid, .sharedOperandBus, .ipIn);
  mac_alu_datapath dut_u (.clk_sys, .rstn, .clkEn, .ctrl, .ctrlValid, .sharedOperandBus, .ipIn,
    .userInputZero, .userInputOne, .userOutputZero, .userOutputOne, .status, .accOut, .statusReg, .ready);

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // compares and instruction helpers
  // ----------------------------------------------------------------
  task automatic cmpAcc(input logic [23:0] got, input logic [23:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmpWord(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run(input alu_op_t o, input logic p, input logic [15:0] b);
    c = '0;
    c.aluOp = o;
    c.aluSelProd = p;
    seq_u.issue(c, b, 16'h0000);
  endtask

  task automatic wsr(input logic [15:0] b);
    c = '0;
    c.writeSr = 1'b1;
    seq_u.issue(c, b, 16'h0000);
  endtask

  task automatic aluStep(input alu_op_t o, input logic p, input logic [15:0] b, input logic [23:0] e);
    run(o, p, b);
    seq_u.settle(1);
    cmpAcc(accOut, e);
  endtask

  // readData stands only for the cycle after the read, so look at once
  task automatic rdChk(input rd_src_t s, input logic [15:0] e);
    c = '0;
    c.readSrc = s;
    seq_u.issue(c, 16'h0000, 16'h0000);
    seq_u.settle(0);
    cmpWord(status.readData, e);
  endtask

  // x of zero means square y through the bank switch
  task automatic mul(input logic [15:0] x, input logic [15:0] y, input logic s);
    c = '0;
    c.loadX = (x != 16'h0000);
    c.square = (x == 16'h0000);
    seq_u.issue(c, (x != 16'h0000) ? x : y, 16'h0000);
    c = '0;
    c.loadY = 1'b1;
    if (x != 16'h0000)
      seq_u.issue(c, y, 16'h0000);
    c = '0;
    c.mulEn = 1'b1;
    c.prodShiftReq = s;
    seq_u.issue(c, 16'h0000, 16'h0000);
    run(ALU_LOAD, 1'b1, 16'h0000);
    seq_u.settle(1);
  endtask

  task automatic stopTest;
    $display("checks=%0d errors=%0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk_sys);
    errorCnt++;
    stopTest();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    clkEn = 1'b1;
    userInputZero = 1'b0;
    userInputOne = 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    do
      @(negedge clk_sys);
    while (ready !== 1'b1);
    cmpWord(statusReg, SR_RESET);
    cmpWord({14'h0, userOutputOne, userOutputZero}, 16'h0003);
    mul(16'h4000, 16'h4000, 1'b0);
    cmpAcc(accOut, 24'h200000);
    mul(16'h0000, 16'hC000, 1'b0);
    cmpAcc(accOut, 24'h200000);
    rdChk(SRC_X, 16'hC000);
    mul(16'h8000, 16'h8000, 1'b0);
    cmpAcc(accOut, 24'h800000);
    wsr(16'h0200);
    mul(16'h4000, 16'hC000, 1'b1);
    cmpAcc(accOut, 24'hFC0000);
    mul(16'h4000, 16'hC000, 1'b0);
    cmpAcc(accOut, 24'hE00000);
    rdChk(SRC_P, 16'hE000);
    rdChk(SRC_Y, 16'hC000);
    wsr(16'h0100);
    run(ALU_LOAD, 1'b0, 16'h7FFF);
    run(ALU_ADD, 1'b0, 16'h7FFF);
    seq_u.settle(1);
    cmpAcc(accOut, ACC_MAXPOS);
    wsr(16'h0000);
    run(ALU_LOAD, 1'b0, 16'h7FFF);
    run(ALU_ADD, 1'b0, 16'h7FFF);
    seq_u.settle(1);
    cmpAcc(accOut, 24'hFFFE00);
    cmpWord({12'h000, statusReg[15:12]}, 16'h000C);
    rdChk(SRC_ACC, 16'hFFFE);
    run(ALU_SUB, 1'b0, 16'hFFFE);
    seq_u.settle(1);
    cmpAcc(accOut, 24'h000000);
    cmpWord({15'h0, statusReg[SR_ZERO]}, 16'h0001);
    c = '0;
    c.longInstr = 1'b1;
    c.aluOp = ALU_LOAD;
    seq_u.issue(c, 16'h1234, 16'h0000);
    aluStep(ALU_ADD, 1'b0, 16'h0001, 24'h123500);
    aluStep(ALU_AND, 1'b0, 16'h0FF0, 24'h023000);
    aluStep(ALU_OR, 1'b0, 16'h4001, 24'h423100);
    aluStep(ALU_XOR, 1'b0, 16'h0300, 24'h413100);
    aluStep(ALU_SHL, 1'b0, 16'h0000, 24'h826200);
    aluStep(ALU_SHR, 1'b0, 16'h0000, 24'hC13100);
    aluStep(ALU_ABS, 1'b0, 16'h0000, 24'h3ECF00);
    aluStep(ALU_NEG, 1'b0, 16'h0000, 24'hC13100);
    aluStep(ALU_PASS, 1'b0, 16'h5A5A, 24'h5A5A00);
    aluStep(ALU_NOP, 1'b0, 16'hFFFF, 24'h5A5A00);
    aluStep(ALU_ADD, 1'b1, 16'h0000, 24'h3A5A00);
    // a word offered while the clock enable is low must not execute
    @(posedge clk_sys);
    clkEn <= 1'b0;
    run(ALU_LOAD, 1'b0, 16'h7777);
    seq_u.settle(1);
    @(posedge clk_sys);
    clkEn <= 1'b1;
    seq_u.settle(1);
    cmpAcc(accOut, 24'h3A5A00);
    for (int k = 0; k < 4; k++)
    begin
      wsr(16'(k) << 5);
      seq_u.settle(1);
      cmpWord({14'h0, userOutputOne, userOutputZero}, {14'h0, ~2'(k)});
    end
    @(posedge clk_sys);
    userInputOne <= 1'b1;
    seq_u.settle(10);
    cmpWord(statusReg & 16'h0C00, 16'h0800);
    c = '0;
    c.readSrc = SRC_SR;
    seq_u.issue(c, 16'h0000, 16'h0000);
    seq_u.settle(0);
    cmpWord(status.readData & 16'h0C00, 16'h0800);
    @(posedge clk_sys);
    userInputOne <= 1'b0;
    userInputZero <= 1'b1;
    seq_u.settle(10);
    cmpWord(statusReg & 16'h0C00, 16'h0400);
    c = '0;
    c.call = 1'b1;
    seq_u.issue(c, 16'h0000, 16'h0100);
    seq_u.settle(0);
    cmpWord({14'h0, status.busy, ready}, 16'h0002);
    c = '0;
    c.subroutineReturnOp = 1'b1;
    seq_u.issue(c, 16'h0000, 16'h0000);
    seq_u.settle(0);
    cmpWord(status.instructionPointer, 16'h0102);
    cmpWord({15'h0, status.ipLoad}, 16'h0001);
    for (int i = 0; i < STACK_DEP; i++)
    begin
      c = '0;
      c.push = 1'b1;
      seq_u.issue(c, 16'hA000 + 16'(i), 16'h0000);
    end
    // the full flag follows the pointer one edge later
    seq_u.settle(1);
    cmpWord({15'h0, status.stackFull}, 16'h0001);
    for (int i = STACK_DEP - 1; i >= 0; i--)
    begin
      c = '0;
      c.pop = 1'b1;
      c.readSrc = SRC_STACK;
      seq_u.issue(c, 16'h0000, 16'h0000);
      seq_u.settle(0);
      cmpWord(status.readData, 16'hA000 + 16'(i));
    end
    seq_u.settle(0);
    cmpWord({15'h0, status.stackEmpty}, 16'h0001);
    stopTest();
  end
endmodule

//--- testbench/seq_model.sv
// sequencer side: presents one instruction and holds it until taken
// assumes the caller starts each issue at a falling edge
`timescale 1ns/1ps

module seq_model
  import mac_dp_pkg::*;
(
  // clock and handshake
  input  wire logic  clk_sys,
  input  wire logic  ready,
  // instruction
  output dp_ctrl_t   ctrl,
  output logic       ctrlValid,
  output logic [15:0] sharedOperandBus,
  output logic [15:0] ipIn
);
  initial
  begin
    ctrl = '0;
    ctrlValid = 1'b0;
    sharedOperandBus = 16'h0000;
    ipIn = 16'h0000;
  end

  // a refused word is simply held until ready is seen high
  task automatic issue(input dp_ctrl_t c, input logic [15:0] b, input logic [15:0] ip);
    @(posedge clk_sys);
    ctrl <= c;
    ctrlValid <= 1'b1;
    sharedOperandBus <= b;
    ipIn <= ip;
    do
      @(negedge clk_sys);
    while (ready !== 1'b1);
  endtask

  // released bus shows the inverse of the last value, not a stale copy
  task automatic settle(input int n);
    @(posedge clk_sys);
    ctrl <= '0;
    ctrlValid <= 1'b0;
    sharedOperandBus <= ~sharedOperandBus;
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
endmodule
